// [hdl/tl_pkg.sv]
// Package for the timing line code and frame capture register bank.
// Assumes one clock domain and Avalon-MM word registers at four times the index.
package tl_pkg;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RX_FRAME_STATUS = 8'h36;
    localparam logic [7:0] IDX_RX_FRAME_IE = 8'h37;
    localparam logic [7:0] IDX_RX_CODE_STATUS = 8'h38;
    localparam logic [7:0] IDX_RX_CODE_IE = 8'h39;
    localparam logic [7:0] IDX_TX_STATUS = 8'h3A;
    localparam logic [7:0] IDX_TX_IE = 8'h3B;
    localparam logic [7:0] IDX_RX_CODE_CTRL = 8'h40;
    localparam logic [7:0] IDX_TX_CODE_CTRL = 8'h41;
    localparam logic [7:0] IDX_RX_CODE_VALUE = 8'h42;
    localparam logic [7:0] IDX_TX_CODE_VALUE = 8'h43;
    localparam logic [7:0] IDX_ALIGN_CAPTURE = 8'h50;
    localparam logic [7:0] IDX_NON_ALIGN_CAPTURE = 8'h51;
    // Field positions
    localparam int POS_RESET = 7;
    localparam int POS_CLEAR_LEN = 4;
    localparam int POS_FILTER = 1;
    localparam int POS_SEND = 6;
    localparam int POS_TX_DENSITY = 3;
    localparam int POS_TX_MULTIFRAME = 2;
    localparam int POS_TX_RESTORED = 1;
    localparam int POS_TX_LOST = 0;
    localparam int POS_CODE_CLEARED = 1;
    localparam int POS_CODE_DETECTED = 0;
    localparam int POS_ALIGN_MARK = 0;
    // Writable masks and reset values
    localparam logic [7:0] MASK_RX_CODE_CTRL = 8'hBE;
    localparam logic [7:0] MASK_TX_CODE_CTRL = 8'h40;
    localparam logic [7:0] MASK_CODE_BITS = 8'h3F;
    localparam logic [7:0] MASK_TX_STATUS = 8'h0F;
    localparam logic [7:0] MASK_CODE_STATUS = 8'h03;
    localparam logic [7:0] MASK_FRAME_STATUS = 8'h01;
    localparam logic [7:0] RESET_REG = 8'h00;
    // Data link patterns
    localparam logic [7:0] IDLE_FLAG = 8'h7E;
    localparam logic [7:0] CODE_PREAMBLE = 8'hFF;
    localparam int MSG_BITS = 16;
    localparam int CAPTURE_BITS = 8;
    localparam int HIST_LEN = 10;
    localparam int MAJORITY = 7;
    // Clear lengths in message bits: 16, 32, 48, 64
    localparam int CLEAR_UNIT = 16;
    // Validation filter codes
    localparam logic [2:0] FILT_ONE = 3'h0;
    localparam logic [2:0] FILT_THREE = 3'h1;
    localparam logic [2:0] FILT_FIVE = 3'h2;
    localparam logic [2:0] FILT_SEVEN = 3'h3;
    localparam logic [2:0] FILT_MAJORITY = 3'h4;

    typedef struct packed {
        logic valid;
        logic data;
    } tl_dl_rx_t;

    typedef struct packed {
        logic valid;
        logic start;
        logic align;
        logic data;
    } tl_e1_rx_t;

    typedef struct packed {
        logic density_violation;
        logic multiframe;
        logic clock_restored;
        logic clock_lost;
    } tl_tx_events_t;

    typedef enum logic [1:0] {
        TL_HUNT = 2'b01,
        TL_VALID = 2'b10
    } tl_rx_state_t;
endpackage : tl_pkg

// [hdl/tl_code_frame_regs.sv]
// Register bank: transmit interrupt masking, data link code receive and
// transmit controllers, E1 align / non-align frame capture.
// Assumes link strobes and data are synchronous to mclk_in; Avalon-MM master
// holds requests until waitrequest is low.
//
// The Avalon-MM slave port is this design's own decision.
module tl_code_frame_regs #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Avalon-MM slave, byte addressed
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [tl_pkg::DATA_W-1:0] avs_writedata_in,
    output logic [tl_pkg::DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Mode and transmit events
    input wire logic e1_mode_in,
    input wire tl_pkg::tl_tx_events_t tx_events_in,
    // Data link
    input wire tl_pkg::tl_dl_rx_t rx_dl_in,
    input wire logic tx_dl_req_in,
    output logic tx_dl_bit_out,
    // E1 receive stream
    input wire tl_pkg::tl_e1_rx_t rx_e1_in,
    // Interrupt
    output logic interrupt_request_out
);
    import tl_pkg::*;

    initial begin
        if (ADDR_W < 10 || ADDR_W > 32) begin
            $error("tl_code_frame_regs: ADDR_W must be 10..32");
        end
    end

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                       input logic clr_en, input logic [7:0] clr, input logic [7:0] mask);
        w1c = ((cur & ~(clr_en ? clr : 8'h00)) | set) & mask;
    endfunction : w1c

    function automatic logic filter_met(input logic [2:0] filt, input logic [3:0] run,
                                        input logic [HIST_LEN-1:0] hist);
        unique case (filt)
            FILT_ONE: filter_met = (run >= 4'h1);
            FILT_THREE: filter_met = (run >= 4'h3);
            FILT_FIVE: filter_met = (run >= 4'h5);
            FILT_SEVEN: filter_met = (run >= 4'h7);
            FILT_MAJORITY: filter_met = ($countones(hist) >= MAJORITY);
            default: filter_met = 1'b0;
        endcase
    endfunction : filter_met

    // Bus slave: one wait cycle, read data registered
    logic ack_q;
    logic [DATA_W-1:0] rdata_q;
    logic [7:0] idx;
    logic word_ok;
    logic wr_go;
    logic [7:0] wd;
    logic [7:0] rd_mux;

    assign idx = avs_address_in[9:2];
    assign word_ok = (avs_address_in[1:0] == 2'h0) && (ADDR_W == 10 || (avs_address_in >> 10) == '0);
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    assign wr_go = avs_write_in & ack_q & word_ok;
    assign wd = avs_writedata_in[7:0];
    assign avs_readdata_out = rdata_q;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read_in | avs_write_in) & ~ack_q;
        end
    end

    // Registers
    logic [7:0] tx_status_q;
    logic [7:0] tx_ie_q;
    logic [7:0] code_status_q;
    logic [7:0] code_ie_q;
    logic [7:0] frame_status_q;
    logic [7:0] frame_ie_q;
    logic [7:0] rx_ctrl_q;
    logic [7:0] tx_ctrl_q;
    logic [7:0] rx_code_q;
    logic [7:0] tx_code_q;
    logic [7:0] align_cap_q;
    logic [7:0] non_align_cap_q;

    always_comb begin
        unique case (idx)
            IDX_TX_STATUS: rd_mux = tx_status_q;
            IDX_TX_IE: rd_mux = tx_ie_q;
            IDX_RX_CODE_STATUS: rd_mux = code_status_q;
            IDX_RX_CODE_IE: rd_mux = code_ie_q;
            IDX_RX_FRAME_STATUS: rd_mux = frame_status_q;
            IDX_RX_FRAME_IE: rd_mux = frame_ie_q;
            IDX_RX_CODE_CTRL: rd_mux = rx_ctrl_q;
            IDX_TX_CODE_CTRL: rd_mux = tx_ctrl_q;
            IDX_RX_CODE_VALUE: rd_mux = rx_code_q;
            IDX_TX_CODE_VALUE: rd_mux = tx_code_q;
            IDX_ALIGN_CAPTURE: rd_mux = align_cap_q;
            IDX_NON_ALIGN_CAPTURE: rd_mux = non_align_cap_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rdata_q <= '0;
        end else if (avs_read_in & ~ack_q) begin
            rdata_q <= word_ok ? {{(DATA_W-8){1'b0}}, rd_mux} : '0;
        end
    end

    // Control and enable registers; masks keep unused bits at zero
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            tx_ie_q <= RESET_REG;
            code_ie_q <= RESET_REG;
            frame_ie_q <= RESET_REG;
            rx_ctrl_q <= RESET_REG;
            tx_ctrl_q <= RESET_REG;
            tx_code_q <= RESET_REG;
        end else if (wr_go) begin
            if (idx == IDX_TX_IE) tx_ie_q <= wd & MASK_TX_STATUS;
            if (idx == IDX_RX_CODE_IE) code_ie_q <= wd & MASK_CODE_STATUS;
            if (idx == IDX_RX_FRAME_IE) frame_ie_q <= wd & MASK_FRAME_STATUS;
            if (idx == IDX_RX_CODE_CTRL) rx_ctrl_q <= wd & MASK_RX_CODE_CTRL;
            if (idx == IDX_TX_CODE_CTRL) tx_ctrl_q <= wd & MASK_TX_CODE_CTRL;
            if (idx == IDX_TX_CODE_VALUE) tx_code_q <= wd & MASK_CODE_BITS;
        end
    end

    // Transmit status, set wins over a simultaneous clear
    logic [7:0] tx_set;
    assign tx_set = {4'h0, tx_events_in.density_violation, tx_events_in.multiframe,
                     tx_events_in.clock_restored, tx_events_in.clock_lost};

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            tx_status_q <= RESET_REG;
        end else begin
            tx_status_q <= w1c(tx_status_q, tx_set, wr_go && idx == IDX_TX_STATUS, wd, MASK_TX_STATUS);
        end
    end

    // Receive code controller
    logic rst_bit_q;
    logic code_reset;
    logic [2:0] filt_q;
    logic [1:0] clr_len_q;
    tl_rx_state_t rx_state_q;
    logic [MSG_BITS-1:0] rx_sh_q;
    logic [4:0] slot_q;
    logic [5:0] cand_q;
    logic [3:0] run_q;
    logic [HIST_LEN-1:0] hist_q;
    logic [6:0] miss_q;
    logic dl_on;
    logic [MSG_BITS-1:0] rx_win;
    logic msg_hit;
    logic [5:0] msg_code;
    logic slot_end;
    logic [3:0] run_d;
    logic [HIST_LEN-1:0] hist_d;
    logic [6:0] clr_bits;
    logic det_set;
    logic clr_set;

    assign code_reset = rx_ctrl_q[POS_RESET] & ~rst_bit_q;
    assign dl_on = rx_dl_in.valid & ~e1_mode_in;
    // Newest bit at the top; message arrives preamble, 0, six code bits, 0
    assign rx_win = {rx_dl_in.data, rx_sh_q[MSG_BITS-1:1]};
    assign msg_hit = (rx_win[7:0] == CODE_PREAMBLE) && !rx_win[8] && !rx_win[15];
    assign msg_code = rx_win[14:9];
    assign slot_end = (slot_q == 5'(MSG_BITS - 1));
    assign clr_bits = 7'(CLEAR_UNIT) * (7'(clr_len_q) + 7'h1);

    always_comb begin
        run_d = run_q;
        hist_d = hist_q;
        if (msg_hit) begin
            run_d = (msg_code == cand_q && run_q != 4'hF) ? run_q + 4'h1 : 4'h1;
            hist_d = (msg_code == cand_q) ? {hist_q[HIST_LEN-2:0], 1'b1} : {{(HIST_LEN-1){1'b0}}, 1'b1};
        end else if (slot_end) begin
            run_d = 4'h0;
            hist_d = {hist_q[HIST_LEN-2:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rst_bit_q <= 1'b0;
            filt_q <= 3'h0;
            clr_len_q <= 2'h0;
        end else begin
            rst_bit_q <= rx_ctrl_q[POS_RESET];
            if (code_reset) begin
                filt_q <= rx_ctrl_q[POS_FILTER +: 3];
                clr_len_q <= rx_ctrl_q[POS_CLEAR_LEN +: 2];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in || code_reset) begin
            rx_state_q <= TL_HUNT;
            rx_sh_q <= '0;
            slot_q <= 5'h0;
            cand_q <= 6'h0;
            run_q <= 4'h0;
            hist_q <= '0;
            miss_q <= 7'h0;
            det_set <= 1'b0;
            clr_set <= 1'b0;
        end else begin
            det_set <= 1'b0;
            clr_set <= 1'b0;
            if (dl_on) begin
                rx_sh_q <= rx_win;
                slot_q <= (msg_hit || slot_end) ? 5'h0 : slot_q + 5'h1;
                run_q <= run_d;
                hist_q <= hist_d;
                if (msg_hit) begin
                    cand_q <= msg_code;
                end
                unique case (rx_state_q)
                    TL_HUNT: begin
                        if (msg_hit && filter_met(filt_q, run_d, hist_d)) begin
                            rx_state_q <= TL_VALID;
                            det_set <= 1'b1;
                            miss_q <= 7'h0;
                        end
                    end
                    TL_VALID: begin
                        if (msg_hit && msg_code == rx_code_q[5:0]) begin
                            miss_q <= 7'h0;
                        end else if (msg_hit && filter_met(filt_q, run_d, hist_d)) begin
                            det_set <= 1'b1;
                            miss_q <= 7'h0;
                        end else if (miss_q + 7'h1 >= clr_bits) begin
                            rx_state_q <= TL_HUNT;
                            clr_set <= 1'b1;
                            miss_q <= 7'h0;
                        end else begin
                            miss_q <= miss_q + 7'h1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rx_code_q <= RESET_REG;
        end else if (dl_on && msg_hit && !code_reset && filter_met(filt_q, run_d, hist_d)) begin
            rx_code_q <= {2'h0, msg_code};
        end
    end

    // Latched until written with 1; set wins over clear
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            code_status_q <= RESET_REG;
        end else begin
            code_status_q <= w1c(code_status_q, {6'h0, clr_set, det_set},
                                 wr_go && idx == IDX_RX_CODE_STATUS, wd, MASK_CODE_STATUS);
        end
    end

    // Code transmitter: whole messages only, so a change of send bit never cuts one short
    logic [MSG_BITS-1:0] tx_msg_q;
    logic [3:0] tx_cnt_q;
    logic tx_bit_q;
    logic send_on;
    logic [MSG_BITS-1:0] next_msg;

    assign send_on = tx_ctrl_q[POS_SEND] & ~e1_mode_in;
    // Bit 0 goes first: preamble, 0, code bit 0..5, 0
    assign next_msg = send_on ? {1'b0, tx_code_q[5:0], 1'b0, CODE_PREAMBLE}
                              : {IDLE_FLAG, IDLE_FLAG};
    assign tx_dl_bit_out = tx_bit_q;

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            tx_msg_q <= {IDLE_FLAG, IDLE_FLAG};
            tx_cnt_q <= 4'h0;
            tx_bit_q <= 1'b0;
        end else if (tx_dl_req_in) begin
            if (tx_cnt_q == 4'h0) begin
                tx_bit_q <= next_msg[0];
                tx_msg_q <= next_msg;
            end else begin
                tx_bit_q <= tx_msg_q[tx_cnt_q];
            end
            tx_cnt_q <= tx_cnt_q + 4'h1;
        end
    end

    // E1 frame capture
    logic [CAPTURE_BITS-1:0] fr_sh_q;
    logic [3:0] fr_cnt_q;
    logic fr_align_q;
    logic [7:0] pend_align_q;
    logic [7:0] pend_non_align_q;
    logic [CAPTURE_BITS-1:0] fr_win;
    logic fr_first;
    logic align_start;

    assign fr_first = rx_e1_in.valid & rx_e1_in.start;
    assign align_start = fr_first & rx_e1_in.align & e1_mode_in;
    assign fr_win = {fr_sh_q[CAPTURE_BITS-2:0], rx_e1_in.data};

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            fr_sh_q <= '0;
            fr_cnt_q <= 4'h8;
            fr_align_q <= 1'b0;
            pend_align_q <= RESET_REG;
            pend_non_align_q <= RESET_REG;
        end else if (rx_e1_in.valid && e1_mode_in) begin
            fr_sh_q <= fr_win;
            if (fr_first) begin
                fr_cnt_q <= 4'h1;
                fr_align_q <= rx_e1_in.align;
            end else if (fr_cnt_q != 4'h8) begin
                fr_cnt_q <= fr_cnt_q + 4'h1;
                if (fr_cnt_q == 4'h7 && fr_align_q) pend_align_q <= fr_win;
                if (fr_cnt_q == 4'h7 && !fr_align_q) pend_non_align_q <= fr_win;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            align_cap_q <= RESET_REG;
            non_align_cap_q <= RESET_REG;
        end else if (align_start) begin
            align_cap_q <= pend_align_q;
            non_align_cap_q <= pend_non_align_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            frame_status_q <= RESET_REG;
        end else begin
            frame_status_q <= w1c(frame_status_q, {7'h0, align_start},
                                  wr_go && idx == IDX_RX_FRAME_STATUS, wd, MASK_FRAME_STATUS);
        end
    end

    // Interrupt from registered state only
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            interrupt_request_out <= 1'b0;
        end else begin
            interrupt_request_out <= |(tx_status_q & tx_ie_q)
                                   | |(code_status_q & code_ie_q)
                                   | |(frame_status_q & frame_ie_q);
        end
    end
endmodule : tl_code_frame_regs

// [verification/tl_code_frame_regs_asserts.sv]
// Concurrent checks on the code and frame capture register bank.
// Assumes it is bound into the top module and sees only its ports.
module tl_code_frame_regs_asserts import tl_pkg::*; #(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic reset_in,
    // Register bus
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [tl_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [tl_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    // Line side
    input wire logic e1_mode_in,
    input wire tl_pkg::tl_tx_events_t tx_events_in,
    input wire tl_pkg::tl_dl_rx_t rx_dl_in,
    input wire logic tx_dl_req_in,
    input wire logic tx_dl_bit_out,
    input wire tl_pkg::tl_e1_rx_t rx_e1_in,
    input wire logic interrupt_request_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_q;
    logic [3:0] run_q;
    logic cause;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    assign cause = (|tx_events_in) || rx_dl_in.valid || (rx_e1_in.valid && rx_e1_in.start)
        || (avs_write_in && !avs_waitrequest_out);
    always_ff @(posedge mclk_in) begin
        req_q <= tx_dl_req_in && !reset_in;
    end
    // Saturates so a stuck line cannot wrap
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            run_q <= 4'h0;
        end else if (req_q) begin
            run_q <= tx_dl_bit_out ? ((run_q == 4'hF) ? run_q : run_q + 4'h1) : 4'h0;
        end
    end
    sequence bus_wait_s;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    wait_one_cycle_a: assert property (bus_wait_s |=> !avs_waitrequest_out)
        else $error("waitrequest held beyond one cycle");
    wait_needs_req_a: assert property (avs_waitrequest_out |-> (avs_read_in || avs_write_in))
        else $error("waitrequest without a request");
    read_upper_zero_a: assert property (avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    reset_quiet_a: assert property ($fell(reset_in) |-> !interrupt_request_out && !tx_dl_bit_out)
        else $error("outputs active after reset");
    tx_bit_hold_a: assert property (!tx_dl_req_in |=> $stable(tx_dl_bit_out))
        else $error("link bit changed without request");
    tx_ones_run_a: assert property (run_q <= 4'h8)
        else $error("over eight ones in a row");
    irq_fall_cause_a: assert property ($fell(interrupt_request_out) |-> $past(avs_write_in && !avs_waitrequest_out, 2))
        else $error("interrupt fell without a write");
    irq_rise_cause_a: assert property ($rose(interrupt_request_out) |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("interrupt rose without a cause");
endmodule : tl_code_frame_regs_asserts

bind tl_code_frame_regs tl_code_frame_regs_asserts #(.ADDR_W(ADDR_W)) chk_u (.mclk_in, .reset_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .e1_mode_in,
    .tx_events_in, .rx_dl_in, .tx_dl_req_in, .tx_dl_bit_out, .rx_e1_in, .interrupt_request_out);

// [verification/tl_line_model.sv]
// Model of the timing line equipment facing the block.
// Assumes one clock; bits are strobed every other cycle.
module tl_line_model import tl_pkg::*; (
    // Clock
    input wire logic mclk_in,
    // Toward the block
    output tl_pkg::tl_dl_rx_t dl_out,
    output tl_pkg::tl_e1_rx_t e1_out,
    output logic req_out,
    input wire logic tx_bit_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        dl_out = '0;
        e1_out = '0;
        req_out = 1'h0;
    end
    // Released line shows the inverse, never a stale copy
    task automatic dl_bit(input logic b);
        @(posedge mclk_in);
        dl_out <= {1'h1, b};
        @(posedge mclk_in);
        dl_out <= {1'h0, ~b};
    endtask : dl_bit
    task automatic send_msg(input logic [5:0] code);
        for (int i = 0; i < 16; i++) begin
            dl_bit(i < 8 ? 1'h1 : (i == 8 || i == 15) ? 1'h0 : code[i - 9]);
        end
    endtask : send_msg
    task automatic send_zeros(input int n);
        repeat (n) dl_bit(1'h0);
    endtask : send_zeros
    task automatic e1_frame(input logic align, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_in);
            e1_out <= {1'h1, i == 0, align && i == 0, b[7 - i]};
            @(posedge mclk_in);
            e1_out <= {3'h0, ~b[7 - i]};
        end
    endtask : e1_frame
    task automatic tx_bits(output logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk_in);
            req_out <= 1'h1;
            @(posedge mclk_in);
            req_out <= 1'h0;
            @(negedge mclk_in);
            v[i] = tx_bit_in;
        end
    endtask : tx_bits
endmodule : tl_line_model

// [verification/testbench.sv]
// Self-checking bench for the code and frame capture register bank.
// Assumes the line model drives the link side and the bench the bus.
module testbench;
    import tl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, reset_in, avs_read_in, avs_write_in, avs_waitrequest_out, e1_mode_in;
    logic tx_dl_req_in, tx_dl_bit_out, interrupt_request_out;
    logic [9:0] avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    tl_tx_events_t tx_events_in;
    tl_dl_rx_t rx_dl_in;
    tl_e1_rx_t rx_e1_in;
    int fail_count = 0;
    int n_compared = 0;

    tl_code_frame_regs #(.ADDR_W(10)) dut_u (.mclk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
        .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .e1_mode_in, .tx_events_in, .rx_dl_in,
        .tx_dl_req_in, .tx_dl_bit_out, .rx_e1_in, .interrupt_request_out);
    tl_line_model line_u (.mclk_in(mclk_in), .dl_out(rx_dl_in), .e1_out(rx_e1_in), .req_out(tx_dl_req_in),
        .tx_bit_in(tx_dl_bit_out));

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask : cyc
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        @(posedge mclk_in);
        avs_address_in <= {idx, 2'h0};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= {24'h0, wd};
        do @(posedge mclk_in); while (avs_waitrequest_out !== 1'h0);
        rd = avs_readdata_out;
        avs_write_in <= 1'h0;
        avs_read_in <= 1'h0;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'h1, idx, d, rd);
    endtask : wr
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] rd;
        bus(1'h0, idx, 8'h00, rd);
        chk(rd, e);
    endtask : rdchk
    task automatic irq_chk(input logic e);
        chk(32'(interrupt_request_out), 32'(e));
    endtask : irq_chk
    task automatic rx_restart(input logic [1:0] len, input logic [2:0] filt);
        wr(IDX_RX_CODE_CTRL, {2'h0, len, filt, 1'h0});
        wr(IDX_RX_CODE_CTRL, {2'h2, len, filt, 1'h0});
    endtask : rx_restart

    task automatic regs_reset();
        logic [7:0] idx [13] = '{8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h40, 8'h41, 8'h42, 8'h43,
            8'h50, 8'h51, 8'h60};
        foreach (idx[i]) rdchk(idx[i], 32'h0);
    endtask : regs_reset
    task automatic regs_access();
        logic [7:0] idx [8] = '{8'h37, 8'h39, 8'h3B, 8'h40, 8'h41, 8'h43, 8'h42, 8'h60};
        logic [7:0] msk [8] = '{8'h01, 8'h03, 8'h0F, 8'hBE, 8'h40, 8'h3F, 8'h00, 8'h00};
        foreach (idx[i]) begin
            wr(idx[i], 8'hFF);
            rdchk(idx[i], {24'h0, msk[i]});
            wr(idx[i], 8'h00);
        end
    endtask : regs_access
    task automatic tx_stream();
        logic [15:0] v;
        logic [15:0] idl;
        logic [15:0] e;
        logic [5:0] c = 6'h2D;
        for (int i = 0; i < 16; i++) begin
            idl[i] = IDLE_FLAG[7 - i % 8];
            e[i] = i < 8 ? 1'h1 : (i == 8 || i == 15) ? 1'h0 : c[i - 9];
        end
        line_u.tx_bits(v);
        chk(32'(v), 32'(idl));
        wr(IDX_TX_CODE_VALUE, {2'h0, c});
        wr(IDX_TX_CODE_CTRL, 8'h40);
        line_u.tx_bits(v);
        chk(32'(v), 32'(e));
        wr(IDX_TX_CODE_CTRL, 8'h00);
        line_u.tx_bits(v);
        chk(32'(v), 32'(idl));
    endtask : tx_stream
    task automatic rx_detect();
        int need [5] = '{1, 3, 5, 7, 7};
        wr(IDX_RX_CODE_IE, 8'h01);
        foreach (need[i]) begin
            rx_restart(2'h0, 3'(i));
            line_u.send_zeros(16);
            for (int k = 1; k < need[i]; k++) begin
                // A miss in mid-run separates seven of ten from seven in a row
                if (i == 4 && k == 4) line_u.send_zeros(16);
                line_u.send_msg(6'(i + 20));
            end
            cyc(3);
            rdchk(IDX_RX_CODE_STATUS, 32'h0);
            line_u.send_msg(6'(i + 20));
            cyc(3);
            irq_chk(1'h1);
            rdchk(IDX_RX_CODE_STATUS, 32'h1);
            rdchk(IDX_RX_CODE_VALUE, 32'(i + 20));
            wr(IDX_RX_CODE_STATUS, 8'h01);
            cyc(1);
            rdchk(IDX_RX_CODE_STATUS, 32'h0);
            irq_chk(1'h0);
        end
        wr(IDX_RX_CODE_IE, 8'h00);
    endtask : rx_detect
    task automatic rx_clear();
        for (int l = 0; l < 4; l++) begin
            rx_restart(2'(l), 3'h0);
            line_u.send_msg(6'h11);
            cyc(3);
            wr(IDX_RX_CODE_STATUS, 8'h03);
            line_u.send_zeros(16 * (l + 1) - 1);
            cyc(3);
            rdchk(IDX_RX_CODE_STATUS, 32'h0);
            line_u.send_zeros(1);
            cyc(3);
            rdchk(IDX_RX_CODE_STATUS, 32'h2);
        end
        // No reset edge, so the longest clear length must stay in force
        wr(IDX_RX_CODE_CTRL, 8'h80);
        line_u.send_msg(6'h11);
        cyc(3);
        wr(IDX_RX_CODE_STATUS, 8'h03);
        line_u.send_zeros(16);
        cyc(3);
        rdchk(IDX_RX_CODE_STATUS, 32'h0);
    endtask : rx_clear
    task automatic tx_masks();
        for (int b = 0; b < 4; b++) begin
            wr(IDX_TX_IE, 8'(1 << b));
            @(posedge mclk_in);
            tx_events_in <= 4'hF;
            @(posedge mclk_in);
            tx_events_in <= 4'h0;
            cyc(3);
            rdchk(IDX_TX_STATUS, 32'hF);
            irq_chk(1'h1);
            // Other statuses stay set, so a low output proves their masks
            wr(IDX_TX_STATUS, 8'(1 << b));
            cyc(2);
            irq_chk(1'h0);
            wr(IDX_TX_STATUS, 8'hF);
        end
        wr(IDX_TX_IE, 8'h00);
    endtask : tx_masks
    task automatic e1_capture();
        @(posedge mclk_in);
        e1_mode_in <= 1'h1;
        wr(IDX_RX_FRAME_IE, 8'h01);
        line_u.e1_frame(1'h1, 8'h9B);
        line_u.e1_frame(1'h0, 8'hE5);
        line_u.e1_frame(1'h1, 8'h00);
        cyc(2);
        rdchk(IDX_ALIGN_CAPTURE, 32'h9B);
        rdchk(IDX_NON_ALIGN_CAPTURE, 32'hE5);
        rdchk(IDX_RX_FRAME_STATUS, 32'h1);
        irq_chk(1'h1);
        wr(IDX_RX_FRAME_STATUS, 8'h01);
        cyc(2);
        irq_chk(1'h0);
    endtask : e1_capture

    initial begin
        mclk_in = 1'h0;
        forever #12.5 mclk_in = ~mclk_in;
    end
    // Whole run needs a few thousand cycles; far beyond means a hang
    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        conclude();
    end
    initial begin
        reset_in = 1'h1;
        avs_address_in = 10'h000;
        avs_read_in = 1'h0;
        avs_write_in = 1'h0;
        avs_writedata_in = 32'h0;
        e1_mode_in = 1'h0;
        tx_events_in = '0;
        repeat (10) @(posedge mclk_in);
        reset_in <= 1'h0;
        regs_reset();
        regs_access();
        tx_stream();
        rx_detect();
        rx_clear();
        tx_masks();
        e1_capture();
        conclude();
    end
endmodule : testbench
